//--- fad_device.sv
// Purpose: flash end: takes instruction, counts address, decodes command
// Assumes: spi mode 0; link pins sampled by i_clock through two flops
// Notes: data phases are outside this block; it only hands over
`timescale 1ns/1ps
module fad_device (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_enable,
  // link
  fad_link_if.dev link,
  // configuration
  input wire logic i_quad_all_protocol,
  input wire logic i_resume_option,
  input wire logic i_nonvolatile_config_two,
  input wire logic i_soft_reset,
  // decoded results
  output logic o_volatile_config_two,
  output logic o_cmd_valid,
  output logic [7:0] o_opcode,
  output logic [31:0] o_address,
  output logic [2:0] o_addr_bytes,
  output logic o_fail_flags_clear,
  output logic o_resume,
  output logic o_ident_read,
  output logic o_reg_write,
  output logic o_ignored
);

  typedef enum logic [1:0] {
    FAD_DEV_IDLE, FAD_DEV_OPCODE, FAD_DEV_ADDR, FAD_DEV_HOLD
  } fad_dev_state_type;

  ////////////////////////////////////////////////////////////////////////
  // link synchronisers
  logic [1:0] cs_sync, sck_sync;
  logic [3:0] io_meta, io_sync;
  logic sck_last;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_sync <= 2'h3;
      sck_sync <= 2'h0;
      io_meta <= 4'h0;
      io_sync <= 4'h0;
      sck_last <= 1'b0;
    end else if (i_enable) begin
      cs_sync <= {cs_sync[0], link.cs_b};
      sck_sync <= {sck_sync[0], link.sck};
      io_meta <= link.io_in;
      io_sync <= io_meta;
      sck_last <= sck_sync[1];
    end
  end
  wire logic cs_low = !cs_sync[1];
  wire logic sck_rise = sck_sync[1] && !sck_last;
  // quad-all shifts a nibble per edge, else one bit on io0
  wire logic [2:0] step = i_quad_all_protocol ? 3'h4 : 3'h1;

  assign link.io_dev_out = 4'h0;
  assign link.io_dev_oe_b = 4'hf;

  ////////////////////////////////////////////////////////////////////////
  // decoder
  fad_dev_state_type state, next_state;
  logic [7:0] shift, next_shift;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [2:0] byte_cnt, next_byte_cnt;
  logic [2:0] need, next_need;
  logic [31:0] addr, next_addr;
  logic wide_mode, next_wide_mode;
  logic cmd_valid, next_cmd_valid;
  logic clr, next_clr, res, next_res, idr, next_idr, status_config_write, next_wrr;
  logic ign, next_ign;
  logic [7:0] opc, next_opc;
  logic [7:0] byte_in;
  logic [3:0] bit_sum;
  logic strap_done;

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_byte_cnt = byte_cnt;
    next_need = need;
    next_addr = addr;
    next_wide_mode = wide_mode;
    next_cmd_valid = 1'b0;
    next_clr = 1'b0;
    next_res = 1'b0;
    next_idr = 1'b0;
    next_wrr = 1'b0;
    next_ign = 1'b0;
    next_opc = opc;
    bit_sum = bit_cnt + {1'b0, step};
    // msb first, nibble lsb on io0
    byte_in = i_quad_all_protocol ? {shift[3:0], io_sync}
                                  : {shift[6:0], io_sync[0]};
    // the decoder itself must see the strap after a hard reset too
    if (i_soft_reset || !strap_done) begin
      next_wide_mode = i_nonvolatile_config_two;
    end
    case (state)
      FAD_DEV_IDLE: begin
        if (cs_low) begin
          next_state = FAD_DEV_OPCODE;
          next_bit_cnt = 4'h0;
        end
      end
      FAD_DEV_OPCODE: begin
        if (sck_rise) begin
          next_shift = byte_in;
          next_bit_cnt = bit_sum;
          if (bit_sum == fad_pkg::BITS_PER_BYTE) begin
            next_bit_cnt = 4'h0;
            next_opc = byte_in;
            next_byte_cnt = 3'h0;
            next_addr = 32'h0;
            next_need = fad_pkg::fad_addr_bytes(byte_in, wide_mode);
            next_state = FAD_DEV_HOLD;
            if (next_need != fad_pkg::ADDR_BYTES_NONE) begin
              next_state = FAD_DEV_ADDR;
            end else if (byte_in == fad_pkg::OP_IDENT_READ) begin
              next_idr = 1'b1;
              next_cmd_valid = 1'b1;
            end else if (byte_in == fad_pkg::OP_FAIL_FLAGS_CLEAR) begin
              next_clr = !i_resume_option;
              next_res = i_resume_option;
              next_cmd_valid = 1'b1;
            end else if (byte_in == fad_pkg::OP_FAIL_FLAGS_CLEAR_ALT) begin
              next_clr = 1'b1;
              next_cmd_valid = 1'b1;
            end else if (byte_in == fad_pkg::OP_WIDE_ADDR_MODE_ENTRY
                         && !i_quad_all_protocol) begin
              next_wide_mode = 1'b1;
              next_cmd_valid = 1'b1;
            end else if (byte_in == fad_pkg::OP_STATUS_CONFIG_WRITE) begin
              next_wrr = 1'b1;
              next_cmd_valid = 1'b1;
            end else begin
              next_ign = 1'b1;
            end
          end
        end
      end
      FAD_DEV_ADDR: begin
        if (sck_rise) begin
          next_shift = byte_in;
          next_bit_cnt = bit_sum;
          if (bit_sum == fad_pkg::BITS_PER_BYTE) begin
            next_bit_cnt = 4'h0;
            next_addr = {addr[23:0], byte_in};
            next_byte_cnt = byte_cnt + 3'h1;
            if (byte_cnt + 3'h1 == need) begin
              next_cmd_valid = 1'b1;
              next_state = FAD_DEV_HOLD;
            end
          end
        end
      end
      FAD_DEV_HOLD: begin
        // later clocks belong to the data phase or are ignored
      end
      default: next_state = FAD_DEV_IDLE;
    endcase
    if (!cs_low) begin
      next_state = FAD_DEV_IDLE;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= FAD_DEV_IDLE;
      shift <= 8'h0;
      bit_cnt <= 4'h0;
      byte_cnt <= 3'h0;
      need <= 3'h0;
      addr <= 32'h0;
      wide_mode <= 1'b0;
      cmd_valid <= 1'b0;
      clr <= 1'b0;
      res <= 1'b0;
      idr <= 1'b0;
      status_config_write <= 1'b0;
      ign <= 1'b0;
      opc <= 8'h0;
    end else if (i_enable) begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      byte_cnt <= next_byte_cnt;
      need <= next_need;
      addr <= next_addr;
      wide_mode <= next_wide_mode;
      cmd_valid <= next_cmd_valid;
      clr <= next_clr;
      res <= next_res;
      idr <= next_idr;
      status_config_write <= next_wrr;
      ign <= next_ign;
      opc <= next_opc;
    end
  end

  // reset cannot load a port value, so the strap is caught after release
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_done <= 1'b0;
    end else if (i_enable) begin
      strap_done <= 1'b1;
    end
  end
  logic len_bit;
  always_comb begin
    len_bit = strap_done ? wide_mode : i_nonvolatile_config_two;
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_volatile_config_two <= 1'b0;
    end else if (i_enable) begin
      o_volatile_config_two <= len_bit;
    end
  end
  assign o_cmd_valid = cmd_valid;
  assign o_opcode = opc;
  assign o_address = addr;
  assign o_addr_bytes = need;
  assign o_fail_flags_clear = clr;
  assign o_resume = res;
  assign o_ident_read = idr;
  assign o_reg_write = status_config_write;
  assign o_ignored = ign;

endmodule

//--- fad_host.sv
// Purpose: host end: sends instruction and address over the link
// Assumes: spi mode 0; sck made by dividing i_clock
// Notes: caller gives opcode, address and byte count per command
`timescale 1ns/1ps
module fad_host (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_enable,
  // link
  fad_link_if.host link,
  // request
  input wire logic i_start,
  input wire logic [7:0] i_opcode,
  input wire logic [31:0] i_address,
  input wire logic [2:0] i_addr_bytes,
  // status
  output logic o_busy,
  output logic o_done
);

  typedef enum logic [1:0] {
    FAD_HOST_IDLE, FAD_HOST_LOW, FAD_HOST_HIGH, FAD_HOST_END
  } fad_host_state_type;

  fad_host_state_type state, next_state;
  logic [39:0] frame, next_frame;
  logic [5:0] bits_left, next_bits_left;
  logic [1:0] div, next_div;
  logic cs_b, next_cs_b, sck, next_sck, done, next_done;
  logic busy;

  always_comb begin
    next_state = state;
    next_frame = frame;
    next_bits_left = bits_left;
    next_div = div + 2'h1;
    next_cs_b = cs_b;
    next_sck = sck;
    next_done = 1'b0;
    case (state)
      FAD_HOST_IDLE: begin
        next_div = 2'h0;
        if (i_start) begin
          // opcode then address, msb first
          next_frame = {i_opcode, i_address << (6'd32 -
                        {i_addr_bytes, 3'h0})};
          next_bits_left = 6'd8 + {i_addr_bytes, 3'h0};
          next_cs_b = 1'b0;
          next_state = FAD_HOST_LOW;
        end
      end
      FAD_HOST_LOW: begin
        if (div == 2'(fad_pkg::CLK_DIV / 2 - 1)) begin
          next_sck = 1'b1;
          next_state = FAD_HOST_HIGH;
          next_div = 2'h0;
        end
      end
      FAD_HOST_HIGH: begin
        if (div == 2'(fad_pkg::CLK_DIV / 2 - 1)) begin
          next_sck = 1'b0;
          next_div = 2'h0;
          next_frame = frame << 1;
          next_bits_left = bits_left - 6'd1;
          next_state = (bits_left == 6'd1) ? FAD_HOST_END
                                           : FAD_HOST_LOW;
        end
      end
      FAD_HOST_END: begin
        next_cs_b = 1'b1;
        next_done = 1'b1;
        next_state = FAD_HOST_IDLE;
      end
      default: next_state = FAD_HOST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= FAD_HOST_IDLE;
      frame <= 40'h0;
      bits_left <= 6'h0;
      div <= 2'h0;
      cs_b <= 1'b1;
      sck <= 1'b0;
      done <= 1'b0;
      busy <= 1'b0;
    end else if (i_enable) begin
      state <= next_state;
      frame <= next_frame;
      bits_left <= next_bits_left;
      div <= next_div;
      cs_b <= next_cs_b;
      sck <= next_sck;
      done <= next_done;
      busy <= (next_state != FAD_HOST_IDLE);
    end
  end

  assign link.cs_b = cs_b;
  assign link.sck = sck;
  assign link.io_host_out = {3'h0, frame[39]};
  assign link.io_host_oe_b = 4'he;
  assign o_busy = busy;
  assign o_done = done;

endmodule

//--- fad_link_assertions.sv
// Purpose: link protocol checks between the host and decoder ends
// Assumes: spi mode 0, single-bit host, sck divided from i_clock
// Notes: sees only the shared link signals
`timescale 1ns/1ps
module fad_link_assertions (
  // clock and reset
  input logic i_clock,
  input logic i_rst_b,
  // link
  input logic cs_b,
  input logic sck,
  input logic [3:0] io_host_out,
  input logic [3:0] io_host_oe_b,
  input logic [3:0] io_dev_oe_b
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  //////////////////////////////////////////////////////////////////////////
  // sck rises in the current frame; whole bytes mean a multiple of eight
  logic sck_q;
  logic [7:0] rises;
  logic [7:0] next_rises;
  always_comb begin
    next_rises = cs_b ? 8'h00 : rises + {7'h00, sck & ~sck_q};
  end
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sck_q <= 1'b0;
      rises <= 8'h00;
    end else begin
      sck_q <= sck;
      rises <= next_rises;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  sequence s_setup;
    !sck [*2];
  endsequence
  sequence s_high_phase;
    sck [*2] ##1 !sck;
  endsequence
  AST_IDLE_SCK_LOW: assert property (cs_b |-> !sck)
    else $error("sck high while deselected");
  AST_CS_BEFORE_SCK: assert property ($rose(sck) |-> !$past(cs_b))
    else $error("sck rose without chip select");
  AST_CS_SETUP: assert property ($fell(cs_b) |-> s_setup)
    else $error("sck rose too soon after select");
  AST_SCK_HIGH: assert property ($rose(sck) |-> s_high_phase)
    else $error("sck high phase wrong");
  AST_BIT_STABLE: assert property ($rose(sck) |=> $stable(io_host_out[0]))
    else $error("host bit moved while sck high");
  AST_HOST_DRIVES: assert property ($rose(sck) |-> !io_host_oe_b[0])
    else $error("host io0 released at sampling");
  AST_DEV_QUIET: assert property (!cs_b |-> io_dev_oe_b[0])
    else $error("device drives io0 in a frame");
  AST_WHOLE_BYTES: assert property ($rose(cs_b) |->
    rises[2:0] == 3'h0 && rises != 8'h00)
    else $error("frame not whole bytes");
  AST_FRAME_ENDS: assert property ($fell(cs_b) |-> ##[1:300] $rose(cs_b))
    else $error("frame did not end");
endmodule

//--- fad_link_if.sv
// Purpose: spi link between flash decoder and host controller
// Assumes: quad pins resolved by the bench from the enables
// Notes: enables are active low, low means this end drives
`timescale 1ns/1ps
interface fad_link_if;
  logic cs_b;
  logic sck;
  logic [3:0] io_host_out;
  logic [3:0] io_host_oe_b;
  logic [3:0] io_dev_out;
  logic [3:0] io_dev_oe_b;
  logic [3:0] io_in;

  modport dev (
    input cs_b, sck, io_in,
    output io_dev_out, io_dev_oe_b
  );
  modport host (
    output cs_b, sck, io_host_out, io_host_oe_b,
    input io_in
  );
endinterface

//--- fad_pkg.sv
// Purpose: shared constants for the flash instruction and address decoder
// Assumes: spi mode 0, single-bit or quad-all instruction and address phase
// Notes: opcode classes, address widths and timing counts live here
package fad_pkg;

  localparam int ADDR_LEN_BIT = 7;
  localparam int CLK_DIV = 4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [2:0] ADDR_BYTES_NONE = 3'h0;
  localparam logic [2:0] ADDR_BYTES_SHORT = 3'h3;
  localparam logic [2:0] ADDR_BYTES_LONG = 3'h4;

  localparam logic [7:0] OP_IDENT_READ = 8'h9f;
  localparam logic [7:0] OP_PARAM_TABLE_READ = 8'h5a;
  localparam logic [7:0] OP_FAIL_FLAGS_CLEAR = 8'h30;
  localparam logic [7:0] OP_FAIL_FLAGS_CLEAR_ALT = 8'h82;
  localparam logic [7:0] OP_WIDE_ADDR_MODE_ENTRY = 8'hb7;
  localparam logic [7:0] OP_STATUS_CONFIG_WRITE = 8'h01;

  typedef enum logic [2:0] {
    FAD_CMD_NONE,
    FAD_CMD_ADDRESSED,
    FAD_CMD_IDENT,
    FAD_CMD_CLEAR,
    FAD_CMD_RESUME,
    FAD_CMD_WIDE_ENTRY,
    FAD_CMD_REG_WRITE
  } fad_cmd_type;

  // opcodes that always carry a 32-bit address
  function automatic logic fad_is_wide(input logic [7:0] op);
    case (op)
      8'h13, 8'h0c, 8'hbc, 8'hec, 8'hee: fad_is_wide = 1'b1;
      8'h12, 8'h21, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3:
        fad_is_wide = 1'b1;
      default: fad_is_wide = 1'b0;
    endcase
  endfunction

  // legacy opcodes whose width follows the address-length bit
  function automatic logic fad_is_legacy(input logic [7:0] op);
    case (op)
      8'h03, 8'h0b, 8'hbb, 8'heb, 8'hed, 8'h02, 8'h20, 8'hd8, 8'h65,
      8'h71, 8'hd0, 8'h42, 8'h4b, 8'hfa, 8'hfb, 8'hfc, 8'hfd:
        fad_is_legacy = 1'b1;
      default: fad_is_legacy = 1'b0;
    endcase
  endfunction

  // address bytes needed for an opcode; wide_mode is the length bit
  function automatic logic [2:0] fad_addr_bytes(input logic [7:0] op,
                                               input logic wide_mode);
    if (fad_is_wide(op)) begin
      fad_addr_bytes = ADDR_BYTES_LONG;
    end else if (fad_is_legacy(op)) begin
      fad_addr_bytes = wide_mode ? ADDR_BYTES_LONG
                                 : ADDR_BYTES_SHORT;
    end else if (op == OP_PARAM_TABLE_READ) begin
      fad_addr_bytes = ADDR_BYTES_SHORT;
    end else begin
      fad_addr_bytes = ADDR_BYTES_NONE;
    end
  endfunction

endpackage

//--- tb.sv
// Purpose: host end drives the decoder end; decodes and wire checked
// Assumes: single-bit host, quad-all off, idle io lines pulled up
// Notes: random addresses and legacy opcodes from a fixed seed
`timescale 1ns/1ps
module tb;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_resume_option = 1'b0;
  logic i_nonvolatile_config_two = 1'b0;
  logic i_soft_reset = 1'b0;
  logic i_start = 1'b0;
  logic [7:0] i_opcode = 8'h00;
  logic [31:0] i_address = 32'h0;
  logic [2:0] i_addr_bytes = 3'h0;
  logic o_busy, o_done, o_volatile_config_two, o_cmd_valid;
  logic o_fail_flags_clear, o_resume, o_ident_read, o_reg_write, o_ignored;
  logic [7:0] o_opcode;
  logic [31:0] o_address;
  logic [2:0] o_addr_bytes;
  logic [5:0] flags;
  logic [39:0] wire_bits;
  logic exp_wide;
  int n_bits;
  int n_errors = 0;
  int tests_run = 0;
  logic [7:0] wide_ops [12] = '{8'h13, 8'h0c, 8'hbc, 8'hec, 8'hee, 8'h12,
    8'h21, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3};
  logic [7:0] legacy_ops [17] = '{8'h03, 8'h0b, 8'hbb, 8'heb, 8'hed, 8'h02,
    8'h20, 8'hd8, 8'h65, 8'h71, 8'hd0, 8'h42, 8'h4b, 8'hfa, 8'hfb, 8'hfc,
    8'hfd};
  always #50 i_clock = ~i_clock;
  //////////////////////////////////////////////////////////////////////////
  fad_link_if lk ();
  // a line nobody drives floats to the pull-up level
  assign lk.io_in = (~lk.io_host_oe_b & lk.io_host_out) |
    (~lk.io_dev_oe_b & lk.io_dev_out) | (lk.io_host_oe_b & lk.io_dev_oe_b);
  fad_host u_fad_host (.i_clock, .i_rst_b, .i_enable(1'b1), .link(lk),
    .i_start, .i_opcode, .i_address, .i_addr_bytes, .o_busy, .o_done);
  fad_device u_fad_device (.i_clock, .i_rst_b, .i_enable(1'b1), .link(lk),
    .i_quad_all_protocol(1'b0), .i_resume_option, .i_nonvolatile_config_two,
    .i_soft_reset, .o_volatile_config_two, .o_cmd_valid, .o_opcode,
    .o_address, .o_addr_bytes, .o_fail_flags_clear, .o_resume,
    .o_ident_read, .o_reg_write, .o_ignored);
  fad_link_assertions u_fad_link_assertions (.i_clock, .i_rst_b,
    .cs_b(lk.cs_b), .sck(lk.sck), .io_host_out(lk.io_host_out),
    .io_host_oe_b(lk.io_host_oe_b), .io_dev_oe_b(lk.io_dev_oe_b));
  //////////////////////////////////////////////////////////////////////////
  // wire capture kept apart from the device's own shifter
  always @(posedge lk.sck) begin
    if (lk.cs_b === 1'b0) begin
      wire_bits <= {wire_bits[38:0], lk.io_in[0]};
      n_bits <= n_bits + 1;
    end
  end
  always @(posedge i_clock) begin
    flags <= flags | {o_cmd_valid, o_fail_flags_clear, o_resume,
      o_ident_read, o_reg_write, o_ignored};
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [2:0] exp_bytes(input logic [7:0] op,
                                           input logic w);
    exp_bytes = (op == 8'h5a) ? 3'h3 : 3'h0;
    foreach (wide_ops[i]) if (wide_ops[i] == op) exp_bytes = 3'h4;
    foreach (legacy_ops[i]) if (legacy_ops[i] == op) exp_bytes = w ? 3'h4 : 3'h3;
  endfunction
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic send(input logic [7:0] op, input logic [31:0] ad,
                      input logic [2:0] nb, input logic [5:0] ef);
    int k;
    logic [39:0] ew;
    ew = (nb == 3'h4) ? {op, ad} : (nb == 3'h3) ? {8'h00, op, ad[23:0]}
                                                : {32'h0, op};
    flags = 6'h00;
    wire_bits = 40'h0;
    n_bits = 0;
    i_opcode = op;
    i_address = ad;
    i_addr_bytes = nb;
    i_start = 1'b1;
    @(negedge i_clock);
    i_start = 1'b0;
    check(o_busy, 1'b1);
    k = 0;
    while (o_done !== 1'b1 && k < 400) begin
      @(negedge i_clock);
      k++;
    end
    repeat (8) @(negedge i_clock);
    check(o_busy, 1'b0);
    check(k < 400, 1'b1);
    check(n_bits, 8 + 8 * nb);
    check(wire_bits, ew);
    check(flags, ef);
    if (ef[5]) check(o_opcode, op);
  endtask
  task automatic addressed(input logic [7:0] op);
    logic [2:0] nb;
    logic [31:0] ad;
    nb = exp_bytes(op, exp_wide);
    ad = $urandom();
    if (nb == 3'h3) ad[31:24] = 8'h00;
    send(op, ad, nb, 6'h20);
    check(o_addr_bytes, nb);
    check(o_address, ad);
    check(o_volatile_config_two, exp_wide);
  endtask
  task automatic reload(input logic nv);
    i_nonvolatile_config_two = nv;
    i_soft_reset = 1'b1;
    @(negedge i_clock);
    i_soft_reset = 1'b0;
    repeat (3) @(negedge i_clock);
    exp_wide = nv;
    check(o_volatile_config_two, nv);
  endtask
  task automatic hard_reset(input logic nv);
    i_nonvolatile_config_two = nv;
    i_rst_b = 1'b0;
    repeat (2) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_clock);
    exp_wide = nv;
    check(o_volatile_config_two, nv);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(9));
    exp_wide = 1'b0;
    repeat (12) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (3) @(negedge i_clock);
    check(o_volatile_config_two, 1'b0);
    foreach (wide_ops[i]) addressed(wide_ops[i]);
    foreach (legacy_ops[i]) addressed(legacy_ops[i]);
    addressed(8'h5a);
    send(8'h9f, 32'h0, 3'h0, 6'h24);
    send(8'h30, 32'h0, 3'h0, 6'h30);
    i_resume_option = 1'b1;
    send(8'h30, 32'h0, 3'h0, 6'h28);
    i_resume_option = 1'b0;
    send(8'h82, 32'h0, 3'h0, 6'h30);
    send(8'h01, 32'h0, 3'h0, 6'h22);
    send(8'h5b, 32'h0, 3'h0, 6'h01);
    send(8'hff, 32'h0, 3'h0, 6'h01);
    // clocks after an unknown opcode must decode nothing more
    send(8'h5b, 32'h00a5c3e1, 3'h3, 6'h01);
    send(8'hb7, 32'h0, 3'h0, 6'h20);
    exp_wide = 1'b1;
    check(o_volatile_config_two, 1'b1);
    repeat (10) addressed(legacy_ops[$urandom_range(16)]);
    addressed(8'h5a);
    addressed(8'h13);
    reload(1'b0);
    addressed(8'h03);
    reload(1'b1);
    addressed(8'h0b);
    // every hard reset must take the strap again, either way
    hard_reset(1'b0);
    addressed(8'hfd);
    hard_reset(1'b1);
    addressed(8'h02);
    final_report();
  end
  // about fifty-five frames of at most two hundred cycles each
  initial begin
    #3_000_000;
    n_errors++;
    final_report();
  end
endmodule
